// file: vsp_ctrl.sv
// Rail state control, sense-pin phase configuration and pulse routing.
// Assumes pins and commands synchronous to mclk; the serial bus framing
// lives outside and hands over one decoded command per valid cycle.
//
// What this block does
// - Sample four sense pins during start-up
// - Pin tied to supply reads high, disabled
// - Normally connected pin reads low, operational
// - Decode core and aux phase counts
// - Store detected pins in user config register
// - User config register read-only after init
// - Reject patterns outside the variant's list
// - Unsupported pattern: powered, never switching
// - Aux off ignores commands to rail 01h
// - Driver A follows pulse 1, B pulse 2
// - Driver C takes aux 1 or core 3
// - Main external output carries core pulse 3 in the two-core variant
// - Main external output carries aux pulse 2 in the three-core variant
// - Aux external output from aux 1 or 2
// - Zero code forces safe outputs, detection off
// - Zero code: rail good follows 34h bit 0
// - Code step 5 mV, FFh is 1.52 V
`timescale 1ns/10ps
`default_nettype none

module vsp_ctrl
	import vsp_pkg::*;
#(
	parameter logic THREE_CORE_DRV = 1'b0
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic enable_in,
	input wire logic undervoltage_lockout_ok,
	input wire logic core_phase2_sense_pin,
	input wire logic core_phase3_sense_pin,
	input wire logic aux_phase1_sense_pin,
	input wire logic aux_phase2_sense_pin,
	input wire logic [2:0] core_pulse,
	input wire logic [1:0] aux_pulse,
	input wire logic driver_enable_line_i,
	output logic driver_enable_line_o,
	output logic driver_enable_line_oe,
	input wire vsp_cmd_t cmd,
	output vsp_rsp_t rsp,
	output vsp_gate_t driver_a_gates,
	output vsp_gate_t driver_b_gates,
	output vsp_gate_t driver_c_gates,
	output logic ext_pulse_out_main,
	output logic ext_pulse_out_aux,
	output logic [1:0] rail_good_out,
	output logic [1:0] err_amp_hold_low,
	output logic [1:0] ovuv_detect_en,
	output logic [17:0] core_target_10uv,
	output logic [17:0] aux_target_10uv,
	output vsp_state_t state_out
);

	typedef struct packed {
		vsp_state_t st;
		logic cfg_done;
		logic [7:0] user_config_reg;
		logic [7:0] mrc;
		logic [7:0] vcode_core;
		logic [7:0] vcode_aux;
		logic [11:0] dly;
		vsp_rsp_t rsp;
		vsp_gate_t drv_a;
		vsp_gate_t drv_b;
		vsp_gate_t drv_c;
		logic ext_main;
		logic ext_aux;
		logic den_o;
		logic den_oe;
		logic [1:0] good;
		logic [1:0] amp_low;
		logic [1:0] ovuv_en;
		logic [17:0] tgt_core;
		logic [17:0] tgt_aux;
	} vsp_regs_t;

	vsp_regs_t s_reg;
	vsp_regs_t s_next;
	localparam vsp_regs_t REGS_RESET = '{
		st: ST_DISABLED, cfg_done: 1'b0, user_config_reg: UCR_RESET, mrc: MRC_RESET,
		vcode_core: VCODE_RESET, vcode_aux: VCODE_RESET, default: '0};
	localparam logic [11:0] STARTUP_LAST = 12'(STARTUP_CYCLES - 1);
	localparam logic [11:0] SOFT_LAST = 12'(SOFT_START_CYCLES - 1);

	// Code to target; zero gives no target at all
	function automatic logic [17:0] code_to_target(input logic [7:0] code);
		logic [17:0] steps;
		steps = 18'(VOLT_CODE_MAX - code);
		if (code == VOLT_CODE_ZERO) begin
			return 18'h00000;
		end
		return 18'(VOLT_CODE_FF_10UV - 18'(steps * VOLT_STEP_10UV));
	endfunction

	// Pins as captured: high means phase disabled
	logic [1:0] core_pair;
	logic [1:0] aux_pair;
	logic unsupported;
	logic aux_off;
	logic core_three;
	logic aux_two;
	logic aux_one;
	logic running;
	logic core_zero;
	logic aux_zero;
	logic [1:0] pin_core_pair;
	logic [1:0] pin_aux_pair;
	logic pin_unsup;

	assign pin_core_pair = {core_phase2_sense_pin, core_phase3_sense_pin};
	assign pin_aux_pair = {aux_phase1_sense_pin, aux_phase2_sense_pin};
	// Both variants reject the same patterns, so one check serves both
	assign pin_unsup = (pin_core_pair == PAIR_FIRST_HIGH) ||
		(pin_aux_pair == PAIR_FIRST_HIGH) ||
		(pin_core_pair == PAIR_BOTH_HIGH && pin_aux_pair == PAIR_BOTH_LOW);

	assign core_pair = s_reg.user_config_reg[3:2];
	assign aux_pair = s_reg.user_config_reg[1:0];
	assign unsupported = s_reg.user_config_reg[UCR_UNSUP_BIT];
	assign core_three = core_pair == PAIR_BOTH_LOW;
	assign aux_two = aux_pair == PAIR_BOTH_LOW;
	assign aux_one = aux_pair == PAIR_SECOND_HIGH;
	assign aux_off = s_reg.cfg_done && aux_pair == PAIR_BOTH_HIGH;
	assign running = s_reg.st == ST_SOFT_START || s_reg.st == ST_NORMAL;
	assign core_zero = s_reg.vcode_core == VOLT_CODE_ZERO;
	assign aux_zero = s_reg.vcode_aux == VOLT_CODE_ZERO;

	// Gate pair for one integrated driver
	function automatic vsp_gate_t gate_of(input logic active, input logic zero,
			input logic pulse);
		vsp_gate_t g;
		g = '{hs: 1'b0, ls: 1'b0};
		if (active && zero) begin
			g = '{hs: 1'b0, ls: 1'b1};
		end else if (active) begin
			g = '{hs: pulse, ls: ~pulse};
		end
		return g;
	endfunction

	always_comb begin
		logic cmd_ok;
		logic c_on;
		logic a_on;
		logic drv_c_aux;
		logic drv_c_core;
		s_next = s_reg;
		cmd_ok = 1'b0;
		c_on = 1'b0;
		a_on = 1'b0;
		drv_c_aux = 1'b0;
		drv_c_core = 1'b0;
		s_next.rsp.ack = 1'b0;

		// Rail state sequence
		case (s_reg.st)
			ST_DISABLED: begin
				s_next.dly = '0;
				if (enable_in && undervoltage_lockout_ok) begin
					s_next.st = ST_STARTUP;
				end
			end
			ST_STARTUP: begin
				if (!s_reg.cfg_done) begin
					s_next.user_config_reg = {pin_unsup, 3'h0, pin_core_pair, pin_aux_pair};
					s_next.cfg_done = 1'b1;
				end
				s_next.dly = s_reg.dly + 12'h001;
				if (!(enable_in && undervoltage_lockout_ok)) begin
					s_next.st = ST_DISABLED;
				end else if (s_reg.cfg_done && unsupported) begin
					s_next.st = ST_UNSUPPORTED;
				end else if (s_reg.cfg_done && s_reg.dly >= STARTUP_LAST) begin
					s_next.dly = '0;
					s_next.st = driver_enable_line_i ? ST_SOFT_START : ST_DRV_FAULT;
				end
			end
			ST_DRV_FAULT: begin
				s_next.dly = '0;
				if (!(enable_in && undervoltage_lockout_ok)) begin
					s_next.st = ST_DISABLED;
				end else if (driver_enable_line_i) begin
					s_next.st = ST_SOFT_START;
				end
			end
			ST_SOFT_START, ST_NORMAL: begin
				if (s_reg.dly < SOFT_LAST) begin
					s_next.dly = s_reg.dly + 12'h001;
				end
				if (s_reg.st == ST_SOFT_START && s_reg.dly >= SOFT_LAST) begin
					s_next.st = ST_NORMAL;
				end
				if (!(enable_in && undervoltage_lockout_ok)) begin
					s_next.st = ST_DISABLED;
				end else if (!driver_enable_line_i) begin
					s_next.st = ST_DRV_FAULT;
				end
			end
			ST_UNSUPPORTED: begin
				// Stays powered; only a power-on reset leaves this state
				s_next.st = ST_UNSUPPORTED;
			end
			default: begin
				s_next.st = ST_DISABLED;
			end
		endcase

		// Register commands; aux rail gone means no answer at all
		if (cmd.valid) begin
			if (cmd.rail == CORE_RAIL_ADDR) begin
				cmd_ok = 1'b1;
			end else if (cmd.rail == AUX_RAIL_ADDR && !aux_off) begin
				cmd_ok = 1'b1;
			end
		end
		if (cmd_ok) begin
			s_next.rsp.ack = 1'b1;
			s_next.rsp.rdata = 8'h00;
			case (cmd.addr)
				VCODE_OFFSET: begin
					if (cmd.write && cmd.rail == CORE_RAIL_ADDR) begin
						s_next.vcode_core = cmd.wdata;
					end else if (cmd.write) begin
						s_next.vcode_aux = cmd.wdata;
					end
					s_next.rsp.rdata = (cmd.rail == CORE_RAIL_ADDR) ?
						s_reg.vcode_core : s_reg.vcode_aux;
				end
				MRC_OFFSET: begin
					if (cmd.write) begin
						s_next.mrc = cmd.wdata;
					end
					s_next.rsp.rdata = s_reg.mrc;
				end
				UCR_OFFSET: begin
					// Writes dropped: contents only come from the pins
					s_next.rsp.rdata = s_reg.user_config_reg;
				end
				default: begin
					s_next.rsp.rdata = 8'h00;
				end
			endcase
		end

		// Output stage; idle states give quiet pins
		c_on = running;
		a_on = running && !aux_off;
		drv_c_aux = !THREE_CORE_DRV && (aux_two || aux_one);
		drv_c_core = THREE_CORE_DRV && core_three;
		s_next.drv_a = gate_of(c_on, core_zero, core_pulse[0]);
		s_next.drv_b = gate_of(c_on, core_zero, core_pulse[1]);
		if (drv_c_aux) begin
			s_next.drv_c = gate_of(a_on, aux_zero, aux_pulse[0]);
		end else begin
			s_next.drv_c = gate_of(c_on && drv_c_core, core_zero,
				core_pulse[2]);
		end
		s_next.ext_main = 1'b0;
		if (!THREE_CORE_DRV && core_three) begin
			s_next.ext_main = c_on && !core_zero && core_pulse[2];
		end else if (THREE_CORE_DRV && aux_two) begin
			s_next.ext_main = a_on && !aux_zero && aux_pulse[1];
		end
		s_next.ext_aux = 1'b0;
		if (!THREE_CORE_DRV && aux_two) begin
			s_next.ext_aux = a_on && !aux_zero && aux_pulse[1];
		end else if (THREE_CORE_DRV && (aux_two || aux_one)) begin
			s_next.ext_aux = a_on && !aux_zero && aux_pulse[0];
		end

		// Enable line: driven low when idle, released in fault, high running
		s_next.den_o = running;
		s_next.den_oe = s_reg.st != ST_DRV_FAULT;

		s_next.amp_low = {!a_on || aux_zero, !c_on || core_zero};
		s_next.ovuv_en = {a_on && !aux_zero, c_on && !core_zero};
		s_next.good = 2'b00;
		if (s_reg.st == ST_NORMAL) begin
			s_next.good[0] = core_zero ? s_reg.mrc[MRC_RAIL_GOOD_BIT] : 1'b1;
			if (!aux_off) begin
				s_next.good[1] = aux_zero ? s_reg.mrc[MRC_RAIL_GOOD_BIT] : 1'b1;
			end
		end
		s_next.tgt_core = code_to_target(s_reg.vcode_core);
		s_next.tgt_aux = code_to_target(s_reg.vcode_aux);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= REGS_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign driver_enable_line_o = s_reg.den_o;
	assign driver_enable_line_oe = s_reg.den_oe;
	assign rsp = s_reg.rsp;
	assign driver_a_gates = s_reg.drv_a;
	assign driver_b_gates = s_reg.drv_b;
	assign driver_c_gates = s_reg.drv_c;
	assign ext_pulse_out_main = s_reg.ext_main;
	assign ext_pulse_out_aux = s_reg.ext_aux;
	assign rail_good_out = s_reg.good;
	assign err_amp_hold_low = s_reg.amp_low;
	assign ovuv_detect_en = s_reg.ovuv_en;
	assign core_target_10uv = s_reg.tgt_core;
	assign aux_target_10uv = s_reg.tgt_aux;
	assign state_out = s_reg.st;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence first_startup;
		s_reg.st == ST_STARTUP && !s_reg.cfg_done;
	endsequence
	sequence pins_latched;
		s_reg.user_config_reg[3:0] == $past(
			{pin_core_pair, pin_aux_pair}) && s_reg.cfg_done;
	endsequence
	chk_cfg_capture_once: assert property (first_startup |=> pins_latched)
		else $error("sense pins not latched at first start-up");
	chk_ucr_read_only: assert property (s_reg.cfg_done |=> $stable(s_reg.user_config_reg))
		else $error("user config register changed after init");
	chk_decode_reject: assert property (first_startup ##1 s_reg.cfg_done |->
		s_reg.user_config_reg[UCR_UNSUP_BIT] == $past(pin_unsup))
		else $error("unsupported flag wrong");
	chk_unsup_no_switch: assert property (s_reg.cfg_done && unsupported |=>
		!s_reg.drv_a.hs && !s_reg.drv_b.hs && !s_reg.drv_c.hs &&
		!s_reg.ext_main && !s_reg.ext_aux)
		else $error("switching with unsupported configuration");
	chk_aux_cmd_ignored: assert property (cmd.valid && aux_off &&
		cmd.rail == AUX_RAIL_ADDR |=> !s_reg.rsp.ack)
		else $error("disabled aux rail answered a command");
	chk_drv_a_follows: assert property (running && !core_zero |=>
		s_reg.drv_a.hs == $past(core_pulse[0]) &&
		s_reg.drv_b.hs == $past(core_pulse[1]))
		else $error("driver A or B not following its pulse");
	chk_zero_code_safe: assert property (running && core_zero |=>
		s_reg.drv_a.ls && s_reg.drv_b.ls && !s_reg.ovuv_en[0] &&
		s_reg.amp_low[0] && s_reg.den_o)
		else $error("zero code outputs not forced");
	chk_zero_code_good: assert property (s_reg.st == ST_NORMAL && core_zero |=>
		s_reg.good[0] == $past(s_reg.mrc[MRC_RAIL_GOOD_BIT]))
		else $error("rail good not following config bit 0");
	chk_fault_released: assert property (s_reg.st == ST_DRV_FAULT &&
		!driver_enable_line_i && enable_in && undervoltage_lockout_ok |=>
		s_reg.st == ST_DRV_FAULT)
		else $error("fault left while line still low");
	chk_idle_quiet: assert property (!running |=> s_reg.good == 2'b00 &&
		!s_reg.ext_main && !s_reg.drv_a.hs)
		else $error("idle state driving outputs");
	chk_code_ff_target: assert property (s_reg.vcode_core == VOLT_CODE_MAX |=>
		s_reg.tgt_core == VOLT_CODE_FF_10UV)
		else $error("full code target wrong");

endmodule

`default_nettype wire

// file: vsp_pkg.sv
// Shared types and constants for the rail state and phase configuration block.
// Assumes a 10 MHz controller clock and a single power-on reset.
package vsp_pkg;

	// Clock period
	localparam int CLK_PERIOD_NS = 100;

	// Start-up delay and soft-start duration, in their own units
	localparam int STARTUP_DELAY_US = 100;
	localparam int SOFT_START_US = 200;
	localparam int STARTUP_CYCLES = (STARTUP_DELAY_US * 1000) / CLK_PERIOD_NS;
	localparam int SOFT_START_CYCLES = (SOFT_START_US * 1000) / CLK_PERIOD_NS;

	// Register offsets on the command port
	localparam logic [7:0] VCODE_OFFSET = 8'h31;
	localparam logic [7:0] MRC_OFFSET = 8'h34;
	localparam logic [7:0] UCR_OFFSET = 8'h35;

	// Reset values
	localparam logic [7:0] MRC_RESET = 8'h00;
	localparam logic [7:0] UCR_RESET = 8'h00;
	localparam logic [7:0] VCODE_RESET = 8'h00;

	// Field positions
	localparam int MRC_RAIL_GOOD_BIT = 0;
	localparam int UCR_UNSUP_BIT = 7;

	// Rail addresses on the command port
	localparam logic [7:0] CORE_RAIL_ADDR = 8'h00;
	localparam logic [7:0] AUX_RAIL_ADDR = 8'h01;

	// Target voltage, in 10 uV units
	localparam logic [17:0] VOLT_CODE_FF_10UV = 18'h251C0;
	localparam logic [17:0] VOLT_STEP_10UV = 18'h001F4;
	localparam logic [7:0] VOLT_CODE_MAX = 8'hFF;
	localparam logic [7:0] VOLT_CODE_ZERO = 8'h00;

	// Sense pin pair patterns, {phase2 pin, phase3 pin} or {aux1, aux2}
	localparam logic [1:0] PAIR_BOTH_LOW = 2'h0;
	localparam logic [1:0] PAIR_SECOND_HIGH = 2'h1;
	localparam logic [1:0] PAIR_FIRST_HIGH = 2'h2;
	localparam logic [1:0] PAIR_BOTH_HIGH = 2'h3;

	typedef enum logic [2:0] {
		ST_DISABLED,
		ST_STARTUP,
		ST_DRV_FAULT,
		ST_SOFT_START,
		ST_NORMAL,
		ST_UNSUPPORTED
	} vsp_state_t;

	typedef struct packed {
		logic hs;
		logic ls;
	} vsp_gate_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] rail;
		logic [7:0] addr;
		logic [7:0] wdata;
	} vsp_cmd_t;

	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
	} vsp_rsp_t;

endpackage

// file: vsp_ext_drv.sv
// External gate driver model sitting on the driver enable line.
// Assumes the line has a resistive pull-up when nobody drives it.
`timescale 1ns/10ps
`default_nettype none

module vsp_ext_drv (
	input wire logic line_o,
	input wire logic line_oe,
	input wire logic hold_low,
	output logic line_level
);
	// Pulling low wins over the controller driving high
	// Letting go means the pull-up brings the line high
	always_comb begin
		if (hold_low) begin
			line_level = 1'b0;
		end else if (line_oe) begin
			line_level = line_o;
		end else begin
			line_level = 1'b1;
		end
	end
endmodule

`default_nettype wire

// file: vr_state_and_phase_config_bench.sv
// Self-checking bench for the rail state and phase configuration block.
// Assumes variant with two core drivers; one POR per sense-pin pattern.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module vr_state_and_phase_config_bench
	import vsp_pkg::*;
;
	typedef struct packed {
		logic rd;
		logic [7:0] val;
	} vsp_note_t;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic enable_in = 1'b0;
	logic undervoltage_lockout_ok = 1'b1;
	logic [3:0] pins = 4'h0;
	logic [2:0] core_pulse = 3'h0;
	logic [1:0] aux_pulse = 2'h0;
	logic hold_low = 1'b0;
	vsp_cmd_t cmd = '0;
	logic line_level, line_o, line_oe, ext_main, ext_aux;
	vsp_rsp_t rsp;
	vsp_gate_t ga, gb, gc, gc_b;
	logic ext_main_b, ext_aux_b;
	logic [1:0] rail_good, hold_amp, ovuv;
	logic [17:0] core_t, aux_t;
	vsp_state_t st;
	int errors = 0;
	int total_checks = 0;
	vsp_note_t notes[$];
	vsp_note_t note;

	vsp_ctrl #(.THREE_CORE_DRV(1'b0)) vsp_ctrl_inst (.mclk(mclk), .rst_n(rst_n),
		.enable_in(enable_in), .undervoltage_lockout_ok(undervoltage_lockout_ok),
		.core_phase2_sense_pin(pins[3]), .core_phase3_sense_pin(pins[2]),
		.aux_phase1_sense_pin(pins[1]), .aux_phase2_sense_pin(pins[0]),
		.core_pulse(core_pulse), .aux_pulse(aux_pulse),
		.driver_enable_line_i(line_level), .driver_enable_line_o(line_o),
		.driver_enable_line_oe(line_oe), .cmd(cmd), .rsp(rsp),
		.driver_a_gates(ga), .driver_b_gates(gb), .driver_c_gates(gc),
		.ext_pulse_out_main(ext_main), .ext_pulse_out_aux(ext_aux),
		.rail_good_out(rail_good), .err_amp_hold_low(hold_amp),
		.ovuv_detect_en(ovuv), .core_target_10uv(core_t),
		.aux_target_10uv(aux_t), .state_out(st));
	vsp_ext_drv vsp_ext_drv_inst (.line_o(line_o), .line_oe(line_oe),
		.hold_low(hold_low), .line_level(line_level));
	// Three-core variant on the same inputs; only its routing is read
	vsp_ctrl #(.THREE_CORE_DRV(1'b1)) vsp_ctrl_b_inst (.mclk(mclk),
		.rst_n(rst_n), .enable_in(enable_in), .undervoltage_lockout_ok(undervoltage_lockout_ok),
		.core_phase2_sense_pin(pins[3]), .core_phase3_sense_pin(pins[2]),
		.aux_phase1_sense_pin(pins[1]), .aux_phase2_sense_pin(pins[0]),
		.core_pulse(core_pulse), .aux_pulse(aux_pulse),
		.driver_enable_line_i(line_level), .driver_enable_line_o(),
		.driver_enable_line_oe(), .cmd(cmd), .rsp(),
		.driver_a_gates(), .driver_b_gates(), .driver_c_gates(gc_b),
		.ext_pulse_out_main(ext_main_b), .ext_pulse_out_aux(ext_aux_b),
		.rail_good_out(), .err_amp_hold_low(), .ovuv_detect_en(),
		.core_target_10uv(), .aux_target_10uv(), .state_out());

	initial begin
		forever #50 mclk = ~mclk;
	end

	task automatic tick(int n);
		repeat (n) @(posedge mclk);
	endtask

	task close_out;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Bounded wait until the state equals s, or leaves s
	task automatic wait_st(vsp_state_t s, bit leave, int bound);
		int i;
		for (i = 0; i < bound; i++) begin
			@(posedge mclk);
			#1;
			if ((st === s) != leave) break;
		end
		if (i == bound) begin
			errors++;
			$display("[FAIL] wait_state expected %h seen %h", s, st);
			close_out;
		end
	endtask

	// Refused commands leave no note, so a stray ack shows up
	task automatic op(logic w, logic [7:0] rail, logic [7:0] addr,
		logic [7:0] data, logic [7:0] ex, bit acc);
		@(posedge mclk);
		cmd <= '{1'b1, w, rail, addr, data};
		if (acc) notes.push_back('{~w, ex});
		@(posedge mclk);
		cmd.valid <= 1'b0;
	endtask

	always @(negedge mclk) begin
		if (rsp.ack === 1'b1) begin
			if (notes.size() == 0) begin
				`CHK("unexpected_ack", 1'b0, 1'b1)
			end else begin
				note = notes.pop_front();
				if (note.rd) `CHK("rdata", note.val, rsp.rdata)
			end
		end
	end

	function automatic bit supp(logic [3:0] p);
		return p inside {4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'hD, 4'hF};
	endfunction

	task automatic run_cfg(logic [3:0] p);
		int cn;
		int an;
		logic [7:0] code;
		logic [2:0] cp;
		logic [1:0] ap;
		cn = (p[3:2] == 2'h0) ? 3 : (p[3:2] == 2'h1) ? 2 : 1;
		an = (p[1:0] == 2'h0) ? 2 : (p[1:0] == 2'h1) ? 1 : 0;
		@(posedge mclk);
		rst_n <= 1'b0;
		enable_in <= 1'b0;
		pins <= p;
		core_pulse <= 3'h7;
		aux_pulse <= 2'h3;
		tick(3);
		rst_n <= 1'b1;
		if (p == 4'h0) begin
			op(1'b0, CORE_RAIL_ADDR, MRC_OFFSET, 8'h00, 8'h00, 1'b1);
			op(1'b0, CORE_RAIL_ADDR, UCR_OFFSET, 8'h00, 8'h00, 1'b1);
			op(1'b0, CORE_RAIL_ADDR, VCODE_OFFSET, 8'h00, 8'h00, 1'b1);
			op(1'b0, CORE_RAIL_ADDR, 8'h40, 8'h00, 8'h00, 1'b1);
		end
		@(posedge mclk);
		enable_in <= 1'b1;
		tick(5);
		#1;
		`CHK("startup_quiet", 6'h00, {rail_good, ga, gb})
		wait_st(ST_STARTUP, 1'b1, 1100);
		op(1'b0, CORE_RAIL_ADDR, UCR_OFFSET, 8'h00, {~supp(p), 3'h0, p}, 1'b1);
		if (!supp(p)) begin
			tick(3);
			#1;
			`CHK("unsup_state", ST_UNSUPPORTED, st)
			`CHK("unsup_quiet", 8'h00, {ga, gb, gc, ext_main, ext_aux})
			$display("test cfg %h done", p);
			return;
		end
		wait_st(ST_NORMAL, 1'b0, 2100);
		tick(2);
		#1;
		`CHK("zero_gates", 6'h14, {ga, gb, ext_main, ext_aux})
		`CHK("zero_amp", 2'h2, {hold_amp[0], ovuv[0]})
		`CHK("zero_good0", 1'b0, rail_good[0])
		op(1'b1, CORE_RAIL_ADDR, MRC_OFFSET, 8'h01, 8'h00, 1'b1);
		tick(3);
		#1;
		`CHK("zero_good1", 1'b1, rail_good[0])
		code = 8'($urandom_range(255, 1));
		op(1'b1, CORE_RAIL_ADDR, VCODE_OFFSET, code, 8'h00, 1'b1);
		tick(3);
		#1;
		`CHK("core_target", 18'(152000 - (255 - code) * 500), core_t)
		// Aux off must not even acknowledge
		op(1'b1, AUX_RAIL_ADDR, VCODE_OFFSET, 8'h80, 8'h00, an != 0);
		tick(3);
		#1;
		`CHK("pending", 0, notes.size())
		`CHK("aux_target", (an != 0) ? 18'(152000 - 127 * 500) : 18'h0, aux_t)
		`CHK("rails", {an != 0, 1'h1, an == 0, 1'h0, an != 0, 3'h7}, {rail_good, hold_amp, ovuv, line_o, line_oe})
		repeat (4) begin
			cp = 3'($urandom);
			ap = 2'($urandom);
			@(posedge mclk);
			core_pulse <= cp;
			aux_pulse <= ap;
			tick(1);
			#1;
			`CHK("gate_a", {cp[0], ~cp[0]}, ga)
			`CHK("gate_b", {cp[1], ~cp[1]}, gb)
			`CHK("gate_c", (an > 0) ? {ap[0], ~ap[0]} : 2'h0, gc)
			`CHK("ext_main", (cn == 3) ? cp[2] : 1'b0, ext_main)
			`CHK("ext_aux", (an == 2) ? ap[1] : 1'b0, ext_aux)
			`CHK("gate_c_b", (cn == 3) ? {cp[2], ~cp[2]} : 2'h0, gc_b)
			`CHK("ext_main_b", (an == 2) ? ap[1] : 1'b0, ext_main_b)
			`CHK("ext_aux_b", (an != 0) ? ap[0] : 1'b0, ext_aux_b)
		end
		op(1'b1, CORE_RAIL_ADDR, UCR_OFFSET, 8'hFF, 8'h00, 1'b1);
		op(1'b0, CORE_RAIL_ADDR, UCR_OFFSET, 8'h00, {4'h0, p}, 1'b1);
		tick(3);
		$display("test cfg %h done", p);
	endtask

	initial begin
		void'($urandom(32'hDE62));
		for (int p = 0; p < 16; p++) begin
			run_cfg(p[3:0]);
		end
		@(posedge mclk);
		hold_low <= 1'b1;
		wait_st(ST_DRV_FAULT, 1'b0, 10);
		tick(1);
		#1;
		`CHK("fault_quiet", 5'h00, {rail_good, ga, line_oe})
		@(posedge mclk);
		hold_low <= 1'b0;
		wait_st(ST_DRV_FAULT, 1'b1, 10);
		`CHK("fault_exit", ST_SOFT_START, st)
		$display("test fault done");
		// Pins changed while disabled must not be picked up again
		@(posedge mclk);
		undervoltage_lockout_ok <= 1'b0;
		wait_st(ST_DISABLED, 1'b0, 10);
		@(posedge mclk);
		pins <= 4'h0;
		undervoltage_lockout_ok <= 1'b1;
		wait_st(ST_STARTUP, 1'b1, 1100);
		op(1'b0, CORE_RAIL_ADDR, UCR_OFFSET, 8'h00, 8'h0F, 1'b1);
		tick(3);
		$display("test recapture done");
		close_out;
	end
endmodule

`default_nettype wire
